// file: verilog/lsp_pkg.sv
// Purpose: Shared constants for the lamp switch PWM timebase.
// Assumes: A 10 MHz reference clock.
// Notes: Times are kept in their own unit; cycle counts derive from them.
`default_nettype none
package lsp_pkg;
  localparam int unsigned LSP_CLK_HZ = 10_000_000;
  localparam int unsigned LSP_CLK_NS = 100;
  // Clock failure thresholds on direct_input_0.
  localparam int unsigned LSP_FAIL_LOW_HZ = 2_000;
  localparam int unsigned LSP_FAIL_HIGH_HZ = 200_000;
  localparam int unsigned LSP_FAIL_LOW_CYC = LSP_CLK_HZ / LSP_FAIL_LOW_HZ;
  localparam int unsigned LSP_FAIL_HIGH_CYC = LSP_CLK_HZ / LSP_FAIL_HIGH_HZ;
  // Output PWM frame and frequency limits.
  localparam int unsigned LSP_STEPS = 128;
  localparam int unsigned LSP_PWM_MAX_HZ = 1_000;
  localparam int unsigned LSP_PWM_DEF_HZ = 120;
  localparam int unsigned LSP_MIN_DIV =
    (LSP_CLK_HZ + LSP_PWM_MAX_HZ * LSP_STEPS - 1) / (LSP_PWM_MAX_HZ * LSP_STEPS);
  localparam int unsigned LSP_DEF_DIV = LSP_CLK_HZ / (LSP_PWM_DEF_HZ * LSP_STEPS);
  // Calibration pulse window on the chip select, in ns.
  localparam int unsigned LSP_CAL_MIN_NS = 20_000;
  localparam int unsigned LSP_CAL_MAX_NS = 200_000;
  localparam int unsigned LSP_CAL_MIN_CYC = (LSP_CAL_MIN_NS + LSP_CLK_NS - 1) / LSP_CLK_NS;
  localparam int unsigned LSP_CAL_MAX_CYC = LSP_CAL_MAX_NS / LSP_CLK_NS;
  // Direct input toggle timeout, in ms.
  localparam int unsigned LSP_TOGGLE_MS = 250;
  localparam int unsigned LSP_TOGGLE_CYC = LSP_TOGGLE_MS * (LSP_CLK_HZ / 1_000);
  // Serial frame layout.
  localparam int unsigned LSP_FRAME_BITS = 16;
  localparam int unsigned LSP_BIT_EN = 15;
  localparam int unsigned LSP_BIT_SEL = 14;
  localparam int unsigned LSP_ST_FAIL = 0;
  localparam int unsigned LSP_ST_TOUT = 1;
  localparam int unsigned LSP_ST_CAL = 2;
  localparam logic [7:0] LSP_DUTY_RST = 8'h00;
  localparam logic [15:0] LSP_DIV_RST = 16'h0000;
endpackage : lsp_pkg
`default_nettype wire

// file: verilog/lsp_sync.sv
// Purpose: Two-flop synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to clk.
// Notes: The first stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none
module lsp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstB,
  // Data.
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rstB)
  begin
    if (!rstB)
    begin
      meta_r <= RST_VAL;
      dout <= RST_VAL;
    end
    else
    begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule : lsp_sync
`default_nettype wire

// file: verilog/lsp_pwm_timebase.sv
// Purpose: PWM timebase, clock-fail watch, calibration and toggle timeout.
// Assumes: All pins are asynchronous and pass two flops first.
// Notes: The serial clock is sampled, so it must be well below ref_clk.
//
// What this block does
// - Flag failure below about 2 kHz.
// - Flag failure above about 200 kHz.
// - Detector runs only when enabled and external.
// - Output PWM from the oscillator never above 1 kHz; on the external clock it runs at the input rate over 128.
// - Uncalibrated oscillator gives about 120 Hz.
// - Calibrated frequency within ten percent.
// - Accept calibration pulse of at least 20 us.
// - Reject calibration pulse over 200 us.
// - Duty zero is off, full is on.
// - At 400 Hz reproduce 10 to 98 percent.
// - At 200 Hz reproduce 5 to 98 percent.
// - Toggle timeout of 250 ms per input.
// - Frames are 16 bits, MSB first.
`timescale 1ns/1ps
`default_nettype none
module lsp_pwm_timebase
  import lsp_pkg::*;
#(
  parameter int unsigned FAIL_LOW_CYC = LSP_FAIL_LOW_CYC,
  parameter int unsigned TOGGLE_CYC = LSP_TOGGLE_CYC
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_b,
  // Direct inputs.
  input wire logic [3:0] directInput,
  // Serial link.
  input wire logic csB,
  input wire logic sclk,
  input wire logic si,
  output logic soOut,
  output logic soOe,
  // Outputs and status.
  output logic [3:0] hsOn,
  output logic clkFail,
  output logic [3:0] toggleTimeout,
  output logic calDone
);
  logic [6:0] syn;
  logic [6:0] synD_r;
  logic [3:0] inS;
  logic csS;
  logic sclkFall;
  logic sclkRise;
  logic csFall;
  logic csRise;
  logic in0Rise;
  logic [15:0] shIn_r;
  logic [15:0] shOut_r;
  logic [4:0] bitCnt_r;
  logic [15:0] lowCnt_r;
  logic pwmEn_r;
  logic clkSel_r;
  logic [7:0] duty_r;
  logic [15:0] calDiv_r;
  logic [15:0] curDiv;
  logic [15:0] divCnt_r;
  logic intTick;
  logic tick;
  logic [6:0] stepCnt_r;
  logic pwmHigh;
  logic monitorOn;
  logic [15:0] periodCnt_r;
  logic failNow_r;
  logic armed_r;
  logic failSet;
  logic [15:0] status;

  // Reset values match the idle pins, so release shows no false edge.
  lsp_sync #(.W(7), .RST_VAL(7'h10)) u_sync (
    .clk(ref_clk),
    .rstB(rst_b),
    .din({si, sclk, csB, directInput}),
    .dout(syn)
  );

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      synD_r <= 7'h10;
    else
      synD_r <= syn;
  end

  assign inS = syn[3:0];
  assign csS = syn[4];
  assign csFall = synD_r[4] & ~syn[4];
  assign csRise = ~synD_r[4] & syn[4];
  assign sclkFall = ~csS & synD_r[5] & ~syn[5];
  assign sclkRise = ~csS & ~synD_r[5] & syn[5];
  assign in0Rise = ~synD_r[0] & syn[0];

  // Serial shifting: SI taken on falling SCLK, SO moves on rising SCLK.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shIn_r <= 16'h0000;
      shOut_r <= 16'h0000;
      bitCnt_r <= 5'h00;
    end
    else if (csFall)
    begin
      shOut_r <= status;
      bitCnt_r <= 5'h00;
    end
    else if (sclkFall)
    begin
      shIn_r <= {shIn_r[14:0], syn[6]};
      if (bitCnt_r != 5'h1f)
        bitCnt_r <= bitCnt_r + 5'h01;
    end
    else if (sclkRise)
      shOut_r <= {shOut_r[14:0], 1'b0};
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      soOut <= 1'b0;
      soOe <= 1'b0;
    end
    else
    begin
      soOut <= shOut_r[15];
      soOe <= ~csS;
    end
  end

  // Length of a chip-select low period, saturating.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      lowCnt_r <= 16'h0000;
    else if (csFall)
      lowCnt_r <= 16'h0001;
    else if (!csS && lowCnt_r != 16'hffff)
      lowCnt_r <= lowCnt_r + 16'h0001;
  end

  // A full frame loads control; a clockless low pulse is a calibration.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pwmEn_r <= 1'b0;
      clkSel_r <= 1'b0;
      duty_r <= LSP_DUTY_RST;
      calDiv_r <= LSP_DIV_RST;
      calDone <= 1'b0;
    end
    else if (csRise)
    begin
      if (bitCnt_r == 5'(LSP_FRAME_BITS))
      begin
        pwmEn_r <= shIn_r[LSP_BIT_EN];
        clkSel_r <= shIn_r[LSP_BIT_SEL];
        duty_r <= shIn_r[7:0];
      end
      else if (bitCnt_r == 5'h00 && lowCnt_r >= 16'(LSP_CAL_MIN_CYC)
               && lowCnt_r <= 16'(LSP_CAL_MAX_CYC))
      begin
        calDiv_r <= lowCnt_r;
        calDone <= 1'b1;
      end
    end
  end

  // The divider floor keeps every setting at or under the top PWM rate.
  assign curDiv = !calDone ? 16'(LSP_DEF_DIV) :
                  (calDiv_r < 16'(LSP_MIN_DIV)) ? 16'(LSP_MIN_DIV) : calDiv_r;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      divCnt_r <= 16'h0000;
    else if (divCnt_r >= curDiv - 16'h0001)
      divCnt_r <= 16'h0000;
    else
      divCnt_r <= divCnt_r + 16'h0001;
  end

  assign intTick = (divCnt_r >= curDiv - 16'h0001);
  // A failing external clock falls back to the oscillator so lamps keep running.
  assign tick = (clkSel_r || failNow_r) ? intTick : in0Rise;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      stepCnt_r <= 7'h00;
    else if (tick)
      stepCnt_r <= stepCnt_r + 7'h01;
  end

  assign pwmHigh = (duty_r == 8'h00) ? 1'b0 :
                   (duty_r >= 8'(LSP_STEPS)) ? 1'b1 :
                   ({1'b0, stepCnt_r} < duty_r);

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      hsOn <= 4'h0;
    else if (pwmEn_r)
      hsOn <= {4{pwmHigh}};
    else
      hsOn <= inS;
  end

  // Clock failure watch on direct_input_0.
  assign monitorOn = pwmEn_r & ~clkSel_r;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      periodCnt_r <= 16'h0000;
      failNow_r <= 1'b0;
      armed_r <= 1'b0;
    end
    else if (!monitorOn)
    begin
      periodCnt_r <= 16'h0000;
      failNow_r <= 1'b0;
      armed_r <= 1'b0;
    end
    else if (in0Rise)
    begin
      // The first rise after the watch starts has no full period behind it.
      periodCnt_r <= 16'h0000;
      armed_r <= 1'b1;
      failNow_r <= armed_r && (periodCnt_r < 16'(LSP_FAIL_HIGH_CYC));
    end
    else
    begin
      if (periodCnt_r != 16'hffff)
        periodCnt_r <= periodCnt_r + 16'h0001;
      if (periodCnt_r >= 16'(FAIL_LOW_CYC))
        failNow_r <= 1'b1;
    end
  end

  assign failSet = monitorOn & ~failNow_r &
                   ((in0Rise && armed_r && periodCnt_r < 16'(LSP_FAIL_HIGH_CYC)) ||
                    (!in0Rise && periodCnt_r >= 16'(FAIL_LOW_CYC)));

  // Sticky flag; a read clears it, but a new failure in that cycle wins.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      clkFail <= 1'b0;
    else if (failSet)
      clkFail <= 1'b1;
    else if (csFall)
      clkFail <= 1'b0;
  end

  always_comb
  begin
    status = 16'h0000;
    status[LSP_ST_FAIL] = clkFail;
    status[LSP_ST_TOUT] = |toggleTimeout;
    status[LSP_ST_CAL] = calDone;
  end

  // One timeout counter per direct input, restarted by any toggle.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_tout
      logic [21:0] toCnt_r;
      always_ff @(posedge ref_clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          toCnt_r <= 22'h000000;
          toggleTimeout[gi] <= 1'b0;
        end
        else if (syn[gi] != synD_r[gi])
        begin
          toCnt_r <= 22'h000000;
          toggleTimeout[gi] <= 1'b0;
        end
        else if (toCnt_r >= 22'(TOGGLE_CYC - 1))
          toggleTimeout[gi] <= 1'b1;
        else
          toCnt_r <= toCnt_r + 22'h000001;
      end
    end
  endgenerate
endmodule : lsp_pwm_timebase
`default_nettype wire

// file: test/lsp_pwm_timebase_asserts.sv
// Purpose: Port checks for the PWM timebase.
// Assumes: Bound to lsp_pwm_timebase.
// Notes: Counters follow raw pins, so bounds carry sync slack.
`timescale 1ns/1ps
`default_nettype none
module lsp_pwm_timebase_asserts
  import lsp_pkg::*;
#(
  parameter int unsigned FAIL_LOW_CYC = 200,
  parameter int unsigned TOGGLE_CYC = 300
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_b,
  // Watched pins.
  input wire logic [3:0] directInput,
  input wire logic csB,
  input wire logic soOe,
  input wire logic [3:0] hsOn,
  input wire logic clkFail,
  input wire logic [3:0] toggleTimeout,
  input wire logic calDone
);
  logic in0D;
  logic in1D;
  int stillCnt;
  int gapCnt;
  int lastGap;
  int lowCnt;
  int lastLow;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      in0D <= 1'b0;
      in1D <= 1'b0;
      stillCnt <= 0;
      gapCnt <= 0;
      lastGap <= 9999;
      lowCnt <= 0;
      lastLow <= 0;
    end
    else
    begin
      in0D <= directInput[0];
      in1D <= directInput[1];
      stillCnt <= (directInput[1] != in1D) ? 0 : stillCnt + 1;
      gapCnt <= (directInput[0] && !in0D) ? 0 : gapCnt + 1;
      if (directInput[0] && !in0D)
        lastGap <= gapCnt;
      lowCnt <= csB ? 0 : lowCnt + 1;
      if (csB && lowCnt != 0)
        lastLow <= lowCnt;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence csIdle;
    csB [*5];
  endsequence
  sequence csBusy;
    !csB [*5];
  endsequence
  oe_idle_a: assert property (csIdle |-> !soOe)
    else $error("so on while idle");
  oe_busy_a: assert property (csBusy |-> soOe)
    else $error("so off while selected");
  fail_hold_a: assert property ((csIdle ##0 clkFail) |=> clkFail)
    else $error("fail flag lost");
  fail_cause_a: assert property ($rose(clkFail) |-> gapCnt >= FAIL_LOW_CYC - 8 || lastGap < 58)
    else $error("fail without cause");
  tout_set_a: assert property (stillCnt >= TOGGLE_CYC + 6 |-> toggleTimeout[1])
    else $error("timeout missing");
  tout_clr_a: assert property (stillCnt > 5 && stillCnt < TOGGLE_CYC - 5 |-> !toggleTimeout[1])
    else $error("timeout early");
  cal_win_a: assert property ($rose(calDone) |-> lastLow >= LSP_CAL_MIN_CYC - 4 && lastLow <= LSP_CAL_MAX_CYC + 4)
    else $error("pulse outside window");
  rst_quiet_a: assert property (disable iff (1'b0) !rst_b |-> hsOn == 4'h0 && !calDone && !clkFail)
    else $error("outputs live in reset");
endmodule : lsp_pwm_timebase_asserts
`default_nettype wire

// file: test/lsp_host_model.sv
// Purpose: Host side of the serial link and timebase pin.
// Assumes: Tasks are called from the bench.
// Notes: The serial clock stands low between frames.
`timescale 1ns/1ps
`default_nettype none
module lsp_host_model (
  // Serial link.
  output logic csB,
  output logic sclk,
  output logic si,
  input wire logic soOut,
  // Timebase pin.
  output logic in0
);
  int in0Half = 0;
  initial
  begin
    csB = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
    in0 = 1'b0;
  end
  always
  begin
    wait (in0Half != 0);
    #(in0Half) in0 = ~in0;
  end
  // Data moves at the rise so it is stable at the fall.
  task automatic frame(input logic [15:0] w, output logic [15:0] rd);
    csB = 1'b0;
    #1000;
    for (int i = 15; i >= 0; i--)
    begin
      rd[i] = soOut;
      sclk = 1'b1;
      si = w[i];
      #400;
      sclk = 1'b0;
      #400;
    end
    si = ~si;
    csB = 1'b1;
    #2000;
  endtask : frame
  task automatic cal(input int ns);
    csB = 1'b0;
    #(ns);
    csB = 1'b1;
    #2000;
  endtask : cal
endmodule : lsp_host_model
`default_nettype wire

// file: test/lsp_pwm_timebase_bench.sv
// Purpose: Self-checking bench for the PWM timebase.
// Assumes: Short timeout parameters.
// Notes: A 21 us pulse sets 210 cycles per step.
`timescale 1ns/1ps
`default_nettype none
module lsp_pwm_timebase_bench;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] dinHi = 3'h0;
  wire logic csB, sclk, si, in0, soOut, soOe, clkFail, calDone;
  wire logic [3:0] hsOn;
  wire logic [3:0] toggleTimeout;
  int nMismatch = 0;
  int numChecks = 0;
  always #50 ref_clk = ~ref_clk;
  lsp_pwm_timebase #(.FAIL_LOW_CYC(200), .TOGGLE_CYC(300)) DUT (.ref_clk(ref_clk),
    .rst_b(rst_b), .directInput({dinHi, in0}), .csB(csB), .sclk(sclk), .si(si),
    .soOut(soOut), .soOe(soOe), .hsOn(hsOn), .clkFail(clkFail),
    .toggleTimeout(toggleTimeout), .calDone(calDone));
  lsp_host_model host (.csB(csB), .sclk(sclk), .si(si), .soOut(soOut), .in0(in0));
  task automatic chk(input logic ok, input string msg);
    numChecks++;
    if (!ok)
    begin
      nMismatch++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #7;
  endtask : cyc
  task automatic meas(input int n, output int hi);
    hi = 0;
    repeat (n)
    begin
      cyc(1);
      hi += (hsOn[0] === 1'b1);
    end
  endtask : meas
  task automatic print_verdict;
    $display("mismatches %0d checks %0d", nMismatch, numChecks);
    if (nMismatch == 0 && numChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic t_idle;
    cyc(320);
    chk(clkFail === 1'b0, "fail while off");
    chk(toggleTimeout === 4'hf, "no timeout");
    dinHi[0] = 1'b1;
    cyc(10);
    chk(toggleTimeout === 4'hd, "timeout kept");
  endtask : t_idle
  task automatic t_cal;
    logic [15:0] rd;
    host.cal(10_000);
    chk(calDone === 1'b0, "short pulse taken");
    host.cal(250_000);
    chk(calDone === 1'b0, "long pulse taken");
    host.cal(21_000);
    chk(calDone === 1'b1, "pulse refused");
    host.frame(16'h0000, rd);
    chk(rd === 16'h0006, "status word");
  endtask : t_cal
  task automatic t_duty;
    logic [15:0] rd;
    int hi;
    host.frame(16'hc000, rd);
    meas(2000, hi);
    chk(hi == 0, "duty zero lit");
    host.frame(16'hc080, rd);
    meas(2000, hi);
    chk(hi == 2000, "full duty dark");
    host.frame(16'hc00d, rd);
    meas(26880, hi);
    chk(hi >= 2520 && hi <= 2940, "ten percent duty");
    host.frame(16'hc007, rd);
    meas(26880, hi);
    chk(hi >= 1323 && hi <= 1617, "five percent duty");
    chk(clkFail === 1'b0, "fail in internal mode");
  endtask : t_duty
  task automatic t_fail;
    logic [15:0] rd;
    host.frame(16'h8040, rd);
    cyc(300);
    chk(clkFail === 1'b1, "stopped clock missed");
    host.in0Half = 9766;
    cyc(600);
    host.frame(16'h8040, rd);
    chk(rd[0] === 1'b1, "fail not latched");
    host.frame(16'h8040, rd);
    chk(rd[0] === 1'b0, "good clock flagged");
    host.in0Half = 200;
    cyc(300);
    chk(clkFail === 1'b1, "fast clock missed");
    host.in0Half = 0;
  endtask : t_fail
  initial
  begin
    cyc(100);
    rst_b = 1'b1;
    t_idle();
    t_cal();
    t_duty();
    t_fail();
    print_verdict();
  end
  initial
  begin
    #9_000_000;
    nMismatch++;
    print_verdict();
  end
endmodule : lsp_pwm_timebase_bench
bind lsp_pwm_timebase lsp_pwm_timebase_asserts #(.FAIL_LOW_CYC(FAIL_LOW_CYC),
  .TOGGLE_CYC(TOGGLE_CYC)) chkr (.ref_clk(ref_clk), .rst_b(rst_b),
  .directInput(directInput), .csB(csB), .soOe(soOe), .hsOn(hsOn), .clkFail(clkFail),
  .toggleTimeout(toggleTimeout), .calDone(calDone));
`default_nettype wire
